/* vsc_pkg.sv */
// package: shared types and constants for voltage scaling control
package vsc_pkg;
  localparam int NCONV = 4;
  localparam int VW = 8;
  localparam int STEPW = 3;
  localparam int FRAME_CYCLES = 32;
  localparam int CNTW = 6;
  localparam int FRAME_IDXW = 5;
  // decoder ranges in millivolts
  localparam int MV_W = 12;
  localparam logic [MV_W-1:0] RANGE0_MAX_MV = 12'h4fb; // 1275 mV, 25 mV steps, clamped to 1100 mV
  localparam logic [MV_W-1:0] RANGE0_STEP_MV = 12'h019;
  localparam logic [MV_W-1:0] RANGE1_MAX_MV = 12'h4b0; // 1200 mV
  localparam logic [MV_W-1:0] RANGE1_STEP_MV = 12'h00a;
  localparam logic [MV_W-1:0] RANGE2_MAX_MV = 12'h578; // 1400 mV
  localparam logic [MV_W-1:0] RANGE2_STEP_MV = 12'h014;
  localparam logic [MV_W-1:0] RANGE3_MAX_MV = 12'h708; // 1800 mV
  localparam logic [MV_W-1:0] RANGE3_STEP_MV = 12'h019;
  localparam logic [MV_W-1:0] CLAMP_25MV_MV = 12'h44c; // 1.1 V
  localparam logic [1:0] RANGE_25MV = 2'h0;
  localparam logic [STEPW:0] RAMP_BASE = 4'h1;

  typedef struct packed {
    logic [VW-1:0] op_volt;
    logic [VW-1:0] alt_volt;
    logic register_select_bit;
    logic default_voltage_bit;
    logic [STEPW-1:0] ramp_step_time;
  } conv_cfg_t;

  typedef struct packed {
    logic duty_decoder_enable;
    logic [1:0] duty_decoder_range;
    logic [1:0] limit_range;
  } dec_cfg_t;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_LOWPWR = 3'b010,
    ST_SPARE = 3'b100
  } pwr_state_t;
endpackage : vsc_pkg

/* duty_decoder.sv */
// duty-count decoder on its own clock, count handed over by toggle
`timescale 1ns/1ps
`default_nettype none
module duty_decoder #(
  parameter int FRAME = vsc_pkg::FRAME_CYCLES
) (
  input wire logic duty_decoder_clock,
  input wire logic rstn,
  input wire logic duty_input,
  output logic [vsc_pkg::CNTW-1:0] count_out,
  output logic frame_toggle
);
  import vsc_pkg::*;
  logic duty_s1_q, duty_s2_q;
  logic [FRAME_IDXW-1:0] idx_q;
  logic [CNTW-1:0] acc_q;
  logic last;
  assign last = (idx_q == FRAME_IDXW'(FRAME - 1));

  always_ff @(posedge duty_decoder_clock or negedge rstn) begin
    if (!rstn) begin
      duty_s1_q <= 1'b0;
      duty_s2_q <= 1'b0;
    end else begin
      duty_s1_q <= duty_input;
      duty_s2_q <= duty_s1_q;
    end
  end

  always_ff @(posedge duty_decoder_clock or negedge rstn) begin
    if (!rstn) idx_q <= '0;
    else idx_q <= last ? '0 : idx_q + 1'b1;
  end

  always_ff @(posedge duty_decoder_clock or negedge rstn) begin
    if (!rstn) begin
      acc_q <= '0;
      count_out <= '0;
      frame_toggle <= 1'b0;
    end else if (last) begin
      count_out <= acc_q + CNTW'(duty_s2_q);
      acc_q <= '0;
      frame_toggle <= ~frame_toggle;
    end else begin
      acc_q <= acc_q + CNTW'(duty_s2_q);
    end
  end

  chk_frame_count_bound: assert property (@(posedge duty_decoder_clock) disable iff (!rstn)
    count_out <= CNTW'(FRAME)) else $error("duty count above frame");
  chk_toggle_frame_end: assert property (@(posedge duty_decoder_clock) disable iff (!rstn)
    $changed(frame_toggle) |-> $past(idx_q) == FRAME_IDXW'(FRAME - 1)) else $error("toggle off frame end");
endmodule // duty_decoder
`default_nettype wire

/* voltage_scaling_control.sv */
// top: pin remap, port routing, voltage selection, ramp, duty decoder
`timescale 1ns/1ps
`default_nettype none
module voltage_scaling_control #(
  parameter int NC = vsc_pkg::NCONV
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic duty_decoder_clock,
  input wire logic duty_input,
  input wire logic pin_remap_strap,
  input wire logic interface_select_strap,
  input wire logic bank_select_strap,
  input wire logic config_state,
  input wire logic low_power_pin,
  input wire logic power_port_clock_pin,
  input wire logic power_port_data_pin,
  input wire logic [NC-1:0] voltage_select_pin,
  input wire logic interrupt_pending,
  input wire logic low_power_enable,
  input wire logic low_power_pin_polarity,
  input wire logic [NC-1:0] enable_set_one_first,
  input wire logic [NC-1:0] enable_set_two_first,
  input wire logic [NC-1:0] enable_set_three_first,
  input wire logic [NC-1:0] power_port_assign,
  input wire vsc_pkg::conv_cfg_t [NC-1:0] conv_cfg,
  input wire vsc_pkg::dec_cfg_t dec_cfg,
  input wire logic std_req_valid,
  input wire logic [1:0] std_req_conv,
  input wire logic pwr_req_valid,
  input wire logic [1:0] pwr_req_conv,
  output logic std_req_refused,
  output logic pwr_req_refused,
  output logic spi_select,
  output logic i2c_gpio_select,
  output logic bank_b_selected,
  output logic low_power_state,
  output logic [NC-1:0] enable_out,
  output logic [NC-1:0][vsc_pkg::VW-1:0] converter_target,
  output logic [NC-1:0][vsc_pkg::VW-1:0] converter_output,
  output logic [vsc_pkg::MV_W-1:0] decoder_mv,
  output logic [1:0] active_range
);
  import vsc_pkg::*;

  // pin synchronisers
  logic [2:0] lp_s1_q, lp_s2_q;
  logic [NC-1:0] sel_s1_q, sel_s2_q;
  logic [2:0] strap_s1_q, strap_s2_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lp_s1_q <= '0;
      lp_s2_q <= '0;
      sel_s1_q <= '0;
      sel_s2_q <= '0;
      strap_s1_q <= '0;
      strap_s2_q <= '0;
    end else begin
      lp_s1_q <= {power_port_data_pin, power_port_clock_pin, low_power_pin};
      lp_s2_q <= lp_s1_q;
      sel_s1_q <= voltage_select_pin;
      sel_s2_q <= sel_s1_q;
      strap_s1_q <= {bank_select_strap, interface_select_strap, pin_remap_strap};
      strap_s2_q <= strap_s1_q;
    end
  end
  logic remap_high, if_strap;
  assign remap_high = strap_s2_q[0];
  assign if_strap = strap_s2_q[1];

  // interface routing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      spi_select <= 1'b0;
      i2c_gpio_select <= 1'b0;
    end else begin
      spi_select <= ~if_strap;
      i2c_gpio_select <= if_strap;
    end
  end

  chk_spi_route: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) |-> spi_select == !$past(if_strap))
    else $error("interface routing wrong");
  chk_route_one_hot: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) |-> spi_select != i2c_gpio_select)
    else $error("both interfaces selected");

  // bank strap latched in configuration state only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) bank_b_selected <= 1'b0;
    else if (config_state) bank_b_selected <= strap_s2_q[2];
  end

  chk_bank_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    !$past(config_state) |-> $stable(bank_b_selected))
    else $error("bank choice moved outside configuration");

  // enable gating from remapped pins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) enable_out <= '0;
    else if (!remap_high)
      enable_out <= ({NC{lp_s2_q[0]}} & enable_set_one_first)
                  | ({NC{lp_s2_q[1]}} & enable_set_two_first)
                  | ({NC{lp_s2_q[2]}} & enable_set_three_first);
    else enable_out <= '0;
  end

  chk_remap_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(remap_high) |-> enable_out == '0)
    else $error("enable pins active with remap high");
  chk_pins_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(lp_s2_q) == 3'h0 |-> enable_out == '0)
    else $error("enable without pin");

  // low-power state machine
  pwr_state_t st_q, st_d;
  logic lp_req;
  assign lp_req = remap_high && low_power_enable && !interrupt_pending
                  && (lp_s2_q[0] == low_power_pin_polarity);
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_ACTIVE: if (lp_req) st_d = ST_LOWPWR;
      ST_LOWPWR: if (!lp_req) st_d = ST_ACTIVE;
      default: st_d = ST_ACTIVE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) st_q <= ST_ACTIVE;
    else st_q <= st_d;
  end
  assign low_power_state = (st_q == ST_LOWPWR);

  chk_lowpower_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    ($rose(low_power_state)) |-> $past(lp_req)) else $error("low-power entered without request");
  chk_lowpower_exit: assert property (@(posedge ref_clk) disable iff (!rstn)
    low_power_state && !lp_req |=> !low_power_state)
    else $error("low-power held without request");
  chk_lowpower_remap: assert property (@(posedge ref_clk) disable iff (!rstn)
    !remap_high |=> !low_power_state)
    else $error("low-power entered with remap low");

  // bus access refusal, decided per request whatever the bit rate
  logic dec_on;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      std_req_refused <= 1'b0;
      pwr_req_refused <= 1'b0;
    end else begin
      std_req_refused <= std_req_valid && (power_port_assign[std_req_conv]
                         || (dec_on && std_req_conv == 2'h0));
      pwr_req_refused <= pwr_req_valid && !power_port_assign[pwr_req_conv];
    end
  end

  chk_std_refuse: assert property (@(posedge ref_clk) disable iff (!rstn)
    std_req_valid && power_port_assign[std_req_conv] |=> std_req_refused) else $error("standard access not refused");
  chk_dec_refuse: assert property (@(posedge ref_clk) disable iff (!rstn)
    std_req_valid && dec_on && std_req_conv == 2'h0 |=> std_req_refused)
    else $error("decoder converter not refused");
  chk_std_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    !std_req_valid |=> !std_req_refused)
    else $error("refusal without request");
  chk_pwr_refuse: assert property (@(posedge ref_clk) disable iff (!rstn)
    pwr_req_valid && !power_port_assign[pwr_req_conv] |=> pwr_req_refused)
    else $error("power port access not refused");
  chk_pwr_accept: assert property (@(posedge ref_clk) disable iff (!rstn)
    pwr_req_valid && power_port_assign[pwr_req_conv] |=> !pwr_req_refused)
    else $error("power port access refused");

  // decoder crossing
  logic [CNTW-1:0] dcount;
  logic dtoggle;
  duty_decoder #(.FRAME(FRAME_CYCLES)) u_dec (
    .duty_decoder_clock(duty_decoder_clock),
    .rstn(rstn),
    .duty_input(duty_input),
    .count_out(dcount),
    .frame_toggle(dtoggle)
  );
  logic tg_s1_q, tg_s2_q, tg_s3_q;
  logic [CNTW-1:0] count_q;
  logic frame_seen_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
    end else begin
      tg_s1_q <= dtoggle;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
    end
  end
  logic frame_done;
  assign frame_done = tg_s2_q ^ tg_s3_q;
  // count changes on the same edge as the toggle, then holds for a whole frame
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
      frame_seen_q <= 1'b0;
    end else if (frame_done) begin
      count_q <= dcount;
      frame_seen_q <= 1'b1;
    end
  end

  chk_count_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
    count_q <= CNTW'(FRAME_CYCLES))
    else $error("crossed count above frame");

  function automatic logic [2*MV_W-1:0] range_of(input logic [1:0] r);
    case (r)
      2'h0: range_of = {RANGE0_MAX_MV, RANGE0_STEP_MV};
      2'h1: range_of = {RANGE1_MAX_MV, RANGE1_STEP_MV};
      2'h2: range_of = {RANGE2_MAX_MV, RANGE2_STEP_MV};
      default: range_of = {RANGE3_MAX_MV, RANGE3_STEP_MV};
    endcase
  endfunction

  logic [MV_W-1:0] rmax, rstep, drop, raw_mv, mv_d;
  logic [2*MV_W-1:0] rsel;
  always_comb begin
    rsel = range_of(dec_cfg.duty_decoder_range);
    rmax = rsel[2*MV_W-1:MV_W];
    rstep = rsel[MV_W-1:0];
    drop = MV_W'(count_q * rstep);
    raw_mv = (drop > rmax) ? '0 : rmax - drop;
    mv_d = raw_mv;
    if (dec_cfg.duty_decoder_range == RANGE_25MV && raw_mv > CLAMP_25MV_MV)
      mv_d = CLAMP_25MV_MV;
  end

  assign dec_on = dec_cfg.duty_decoder_enable;
  // first toggle after reset only loads count_q; in decoder mode the output updates from the next toggle, one frame behind
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) decoder_mv <= '0;
    else if ((frame_done && frame_seen_q) || !dec_on) decoder_mv <= mv_d;
  end

  chk_mv_frame_only: assert property (@(posedge ref_clk) disable iff (!rstn)
    $changed(decoder_mv) |-> $past(frame_done) || !$past(dec_on))
    else $error("decoder output moved mid-frame");

  // range follows decoder field in decoder mode, limit register otherwise
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) active_range <= '0;
    else if (dec_on) active_range <= dec_cfg.duty_decoder_range;
    else active_range <= dec_cfg.limit_range;
  end

  chk_range_restore: assert property (@(posedge ref_clk) disable iff (!rstn)
    !dec_on ##1 !dec_on |-> active_range == $past(dec_cfg.limit_range)) else $error("range not restored");
  chk_clamp_1v1: assert property (@(posedge ref_clk) disable iff (!rstn)
    dec_cfg.duty_decoder_range == RANGE_25MV |-> mv_d <= CLAMP_25MV_MV) else $error("clamp exceeded");
  chk_range_decoder: assert property (@(posedge ref_clk) disable iff (!rstn)
    dec_on |=> active_range == $past(dec_cfg.duty_decoder_range))
    else $error("decoder range not in use");
  chk_zero_count_top: assert property (@(posedge ref_clk) disable iff (!rstn)
    count_q == '0 |-> mv_d >= CLAMP_25MV_MV)
    else $error("zero count below range top");

  // target selection per converter
  function automatic logic pick_alt(input logic remap, input logic pin, input conv_cfg_t c, input logic lp);
    if (!remap) pick_alt = pin;
    else if (lp) pick_alt = c.default_voltage_bit;
    else pick_alt = c.register_select_bit;
  endfunction

  localparam int RCW = 2**STEPW + STEPW + 1;
  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_conv
      logic [VW-1:0] tgt_d;
      logic [RCW-1:0] ramp_q;
      logic [RCW-1:0] ramp_limit;
      always_comb begin
        tgt_d = pick_alt(remap_high, sel_s2_q[g], conv_cfg[g], low_power_state)
                ? conv_cfg[g].alt_volt : conv_cfg[g].op_volt;
      end
      // in decoder mode converter 0 holds its last register target
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) converter_target[g] <= '0;
        else if (!(g == 0 && dec_on)) converter_target[g] <= tgt_d;
      end
      assign ramp_limit = RCW'(RAMP_BASE) << conv_cfg[g].ramp_step_time;
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) ramp_q <= '0;
        else if (ramp_q >= ramp_limit - 1'b1) ramp_q <= '0;
        else ramp_q <= ramp_q + 1'b1;
      end
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) converter_output[g] <= '0;
        else if (ramp_q >= ramp_limit - 1'b1) begin
          if (converter_output[g] < converter_target[g]) converter_output[g] <= converter_output[g] + 1'b1;
          else if (converter_output[g] > converter_target[g]) converter_output[g] <= converter_output[g] - 1'b1;
        end
      end
      chk_ramp_single_step: assert property (@(posedge ref_clk) disable iff (!rstn)
        converter_output[g] != $past(converter_output[g]) |->
        (converter_output[g] == $past(converter_output[g]) + 1'b1
         || converter_output[g] == $past(converter_output[g]) - 1'b1)) else $error("ramp jumped");
      chk_op_select: assert property (@(posedge ref_clk) disable iff (!rstn)
        !remap_high && !(g == 0 && dec_on) && !sel_s2_q[g] |=> converter_target[g] == $past(conv_cfg[g].op_volt))
        else $error("select pin low ignored");
      chk_ramp_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        converter_output[g] == converter_target[g] |=> $stable(converter_output[g]))
        else $error("ramp left its target");
      chk_ramp_up: assert property (@(posedge ref_clk) disable iff (!rstn)
        converter_output[g] < converter_target[g] |=> converter_output[g] >= $past(converter_output[g]))
        else $error("ramp moved away upward");
      chk_ramp_down: assert property (@(posedge ref_clk) disable iff (!rstn)
        converter_output[g] > converter_target[g] |=> converter_output[g] <= $past(converter_output[g]))
        else $error("ramp moved away downward");
    end
  endgenerate

  chk_sel_pin_alt: assert property (@(posedge ref_clk) disable iff (!rstn)
    !remap_high && !dec_on && sel_s2_q[1] && $stable(conv_cfg[1]) |=> converter_target[1] == conv_cfg[1].alt_volt)
    else $error("select pin ignored");
  chk_dec_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    dec_on && $past(dec_on) |-> $stable(converter_target[0])) else $error("register scaling not blocked");
endmodule // voltage_scaling_control
`default_nettype wire

/* duty_host_model.sv */
// host side of the duty decoder link: free-running clock and duty pattern
`timescale 1ns/1ps
`default_nettype none
module duty_host_model (
  input wire logic [5:0] duty_count,
  output logic duty_decoder_clock,
  output logic duty_input
);
  logic [4:0] pos_q;
  // 125 ns period, phase offset from the device clock
  initial begin
    duty_decoder_clock = 1'b0;
    pos_q = 5'h00;
    duty_input = 1'b0;
    #7;
    forever #62.5 duty_decoder_clock = ~duty_decoder_clock;
  end
  // pattern repeats every 32 clocks, so any 32-clock window holds duty_count highs
  // running from time zero, so whole frames precede any enable
  always @(negedge duty_decoder_clock) begin
    pos_q <= pos_q + 5'h01;
    duty_input <= ({1'b0, pos_q} < duty_count);
  end
endmodule // duty_host_model
`default_nettype wire

/* voltage_scaling_control_bench.sv */
// self-checking bench for voltage scaling control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module voltage_scaling_control_bench;
  import vsc_pkg::*;
  logic ref_clk = 0, rstn = 0, duty_decoder_clock, duty_input, pin_remap_strap = 0, interface_select_strap = 0;
  logic bank_select_strap = 1, config_state = 1, low_power_pin = 0, power_port_clock_pin = 0;
  logic power_port_data_pin = 0, interrupt_pending = 0, low_power_enable = 0, low_power_pin_polarity = 0;
  logic [3:0] voltage_select_pin = 4'h0, power_port_assign = 4'h2;
  logic [3:0] enable_set_one_first = 4'h1, enable_set_two_first = 4'h6, enable_set_three_first = 4'h8;
  conv_cfg_t [3:0] conv_cfg = '0;
  dec_cfg_t dec_cfg = '0;
  logic std_req_valid = 0, pwr_req_valid = 0, std_req_refused, pwr_req_refused, spi_select, i2c_gpio_select;
  logic [1:0] std_req_conv = 2'h0, pwr_req_conv = 2'h0, active_range;
  logic bank_b_selected, low_power_state;
  logic [3:0] enable_out;
  logic [3:0][7:0] converter_target, converter_output;
  logic [11:0] decoder_mv;
  logic [5:0] duty_count = 6'h00;
  int n_fail = 0, num_checks = 0, cyc = 0;
  logic [3:0] es[3] = '{4'h1, 4'h6, 4'h8};
  logic [1:0] rg[5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
  logic [5:0] cn[5] = '{6'h00, 6'h07, 6'h05, 6'h14, 6'h20};
  logic [11:0] ev[5] = '{12'h44c, 12'h44c, 12'h47e, 12'h3e8, 12'h3e8};
  // rows: enable, interrupt, polarity, pin, expected low-power state
  logic [4:0] lp[5] = '{5'b10111, 5'b11110, 5'b00110, 5'b10001, 5'b10010};

  voltage_scaling_control dut (.ref_clk, .rstn, .duty_decoder_clock, .duty_input, .pin_remap_strap,
    .interface_select_strap, .bank_select_strap, .config_state, .low_power_pin, .power_port_clock_pin,
    .power_port_data_pin, .voltage_select_pin, .interrupt_pending, .low_power_enable, .low_power_pin_polarity,
    .enable_set_one_first, .enable_set_two_first, .enable_set_three_first, .power_port_assign, .conv_cfg,
    .dec_cfg, .std_req_valid, .std_req_conv, .pwr_req_valid, .pwr_req_conv, .std_req_refused, .pwr_req_refused,
    .spi_select, .i2c_gpio_select, .bank_b_selected, .low_power_state, .enable_out, .converter_target,
    .converter_output, .decoder_mv, .active_range);
  duty_host_model host (.duty_count, .duty_decoder_clock, .duty_input);

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // long enough to cover two decoder clock edges
  task automatic do_reset();
    rstn = 0;
    step(25);
    rstn = 1;
    step(10);
  endtask

  task automatic req(input logic s, input logic [1:0] c, input logic exp);
    std_req_valid = s;
    std_req_conv = c;
    pwr_req_valid = !s;
    pwr_req_conv = c;
    step(1);
    `CHK(s ? std_req_refused : pwr_req_refused, exp)
    std_req_valid = 0;
    pwr_req_valid = 0;
    step(1);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 4; i++) begin
      conv_cfg[i].op_volt = 8'h10 + 8'(i);
      conv_cfg[i].alt_volt = 8'h80 + 8'(i);
      conv_cfg[i].ramp_step_time = (i == 1) ? 3'h7 : 3'h0;
    end
    conv_cfg[2].register_select_bit = 1;
    do_reset();
    config_state = 0;
    bank_select_strap = 0;
    step(5);
    `CHK(bank_b_selected, 1'b1)
    `CHK({spi_select, i2c_gpio_select}, 2'b10)
    for (int i = 0; i < 3; i++) begin
      {power_port_data_pin, power_port_clock_pin, low_power_pin} = 3'(1 << i);
      step(5);
      `CHK(enable_out, es[i])
    end
    {power_port_data_pin, power_port_clock_pin, low_power_pin} = 3'h0;
    for (int p = 0; p < 2; p++) begin
      voltage_select_pin = p ? 4'h5 : 4'ha;
      step(5);
      for (int i = 0; i < 4; i++)
        `CHK(converter_target[i], (voltage_select_pin[i] ? 8'h80 : 8'h10) + 8'(i))
      step(150);
      `CHK(converter_output[0], p ? 8'h80 : 8'h10)
      `CHK(converter_output[1] == (p ? 8'h11 : 8'h81), 1'b0)
    end
    req(1, 1, 1);
    req(0, 1, 0);
    req(1, 2, 0);
    req(0, 2, 1);
    $display("test remap_low done");
    voltage_select_pin = 4'h0;
    dec_cfg.limit_range = 2'h3;
    step(5);
    for (int k = 0; k < 5; k++) begin
      dec_cfg.duty_decoder_range = rg[k];
      duty_count = cn[k];
      if (k == 0) begin
        step(500);
        dec_cfg.duty_decoder_enable = 1;
      end
      if (k == 1) begin
        conv_cfg[0].op_volt = 8'h33;
        req(1, 0, 1);
        `CHK(converter_target[0], 8'h10)
      end
      step(1300);
      `CHK(decoder_mv, ev[k])
      `CHK(active_range, rg[k])
    end
    dec_cfg.duty_decoder_enable = 0;
    step(10);
    `CHK(active_range, 2'h3)
    `CHK(converter_target[0], 8'h33)
    req(1, 0, 0);
    $display("test decoder done");
    pin_remap_strap = 1;
    interface_select_strap = 1;
    do_reset();
    `CHK({spi_select, i2c_gpio_select}, 2'b01)
    {power_port_data_pin, power_port_clock_pin, low_power_pin} = 3'h7;
    step(5);
    `CHK(enable_out, 4'h0)
    for (int k = 0; k < 5; k++) begin
      {low_power_enable, interrupt_pending, low_power_pin_polarity, low_power_pin} = lp[k][4:1];
      step(6);
      `CHK(low_power_state, lp[k][0])
      if (k > 2)
        `CHK(converter_target[2], lp[k][0] ? 8'h12 : 8'h82)
    end
    $display("test remap_high done");
    results();
  end
endmodule // voltage_scaling_control_bench
`default_nettype wire
